// [crank_pulse_measure_channel.sv]
/*
  One measurement channel: edge capture, procedure engine, angle window,
  timeout monitoring and the result write strobe toward the shared result memory.
  Assumes meas_in and crank_angle are synchronous to ref_clk; crank_angle in whole degrees.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Mode 0 measures free running, mode 1 measures crank synchronous.
// - Code -1 disables channel and edges; 0/1 and 59/60 give high/low widths.
// - Code 2 sums active-high time, code 3 sums active-low time.
// - Codes 18/19 give cycle time, codes 4/5 give frequency, rising/falling.
// - Codes 6 to 13 give duty factor and duty cycle ratios on chosen edges.
// - Code 14 reports rising edge angle, code 15 falling edge angle.
// - Code 16 counts low pulses, code 17 counts high pulses.
// - Codes 49/50 report the input level, active high or active low.
// - Timeout 0 off, 1-2 interval, 3-4 angle, 5-6 both; odd preset, even input.
// - Preset timeout modes output the default value; others ignore it.
// - Interval at least 1 ms, used only in interval timeout modes.
// - Check angle within +-720 degrees, used only in angle timeout modes.
// - Window limits within +-720 degrees, applied only in synchronous mode.
// - Additive and count results are written when angle reaches upper limit in synchronous mode, at each closing edge in free running mode.
// - Edge angles are relative to the reference; others ignore it.
// - Sync: pulse-qualified needs both edges in one window, edge-qualified either.
// - Timeout fires when no new value appeared since the previous check.
// - Input-dependent timeout gives 0 if inactive, else time since opening edge.
module crank_pulse_measure_channel
  import cpm_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic                    meas_in,
  input  wire logic signed [ANG_W-1:0] crank_angle,
  input  wire logic                    cfg_sync_mode,
  input  wire logic        [7:0]       cfg_procedure,
  input  wire logic        [2:0]       cfg_timeout_mode,
  input  wire logic        [RES_W-1:0] cfg_default_value,
  input  wire logic        [MS_W-1:0]  cfg_interval_ms,
  input  wire logic signed [ANG_W-1:0] cfg_check_angle,
  input  wire logic signed [ANG_W-1:0] cfg_win_lower,
  input  wire logic signed [ANG_W-1:0] cfg_win_upper,
  input  wire logic signed [ANG_W-1:0] cfg_angle_ref,
  output var  logic        [RES_W-1:0] result_q,
  output var  logic                    result_wr_q,
  output var  logic                    timeout_q,
  output var  logic                    monitor_off_q
);
  typedef struct packed {
    cpm_phase_t        phase;
    logic              in_q;
    logic [ANG_W-1:0]  ang_q;
    logic [RES_W-1:0]  pulse_t;
    logic [RES_W-1:0]  seg_t;
    logic [RES_W-1:0]  per_t;
    logic [RES_W-1:0]  hi_t;
    logic [RES_W-1:0]  lo_t;
    logic [RES_W-1:0]  acc;
    logic [RES_W-1:0]  cnt;
    logic              have_edge;
    logic              open_ok;
    logic              win_cut;
    logic              new_val;
    logic [MS_W-1:0]   ms_cnt;
    logic [RES_W-1:0]  result;
    logic              wr;
    logic              tout;
    logic              mon_off;
  } cpm_state_t;

  localparam cpm_state_t ST_RST = '{phase: CPM_PH_IDLE, result: RESULT_RST, mon_off: 1'b1, default: '0};

  cpm_tick_if tk ();

  cpm_timebase u_timebase (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tk      (tk)
  );

  cpm_state_t        st_q;
  cpm_state_t        st_d;
  logic [7:0]        proc;
  logic              is_wid, is_eq, is_add, is_cnt, is_cyc, is_frq, is_duty, is_ang, is_lvl, is_off;
  logic              act_hi, ref_rise, act_now, act_prev;
  logic              rise, fall, open_e, close_e, ref_e;
  logic              in_win, win_end, chk_cross;
  logic              int_mode, ang_mode, mon, chk_int, check, fire;
  logic              meas_wr;
  logic [RES_W-1:0]  meas_val;
  logic [RES_W-1:0]  hi_n, lo_n, num_d, den_d, acc_n, cnt_n;
  logic [DIV_W-1:0]  num_w, quot;
  logic [ANG_W:0]    ang_diff;
  logic [RES_W-1:0]  ang_rel;
  logic [MS_W-1:0]   ivl_eff;

  assign proc    = cfg_procedure;
  assign is_eq   = (proc == PROC_HI_EQ) || (proc == PROC_LO_EQ);
  assign is_wid  = (proc == PROC_HI_PQ) || (proc == PROC_LO_PQ) || is_eq;
  assign is_add  = (proc == PROC_ADD_HI) || (proc == PROC_ADD_LO);
  assign is_cyc  = (proc == PROC_CYC_R) || (proc == PROC_CYC_F);
  assign is_frq  = (proc == PROC_FREQ_R) || (proc == PROC_FREQ_F);
  assign is_duty = (proc >= PROC_DUTY_LH_R) && (proc <= PROC_DUTY_HT_F);
  assign is_ang  = (proc == PROC_ANG_R) || (proc == PROC_ANG_F);
  assign is_cnt  = (proc == PROC_CNT_LO) || (proc == PROC_CNT_HI);
  assign is_lvl  = (proc == PROC_LVL_HI) || (proc == PROC_LVL_LO);
  assign is_off  = !(is_wid || is_add || is_cyc || is_frq || is_duty || is_ang || is_cnt || is_lvl);

  assign act_hi   = (proc == PROC_HI_PQ) || (proc == PROC_HI_EQ) || (proc == PROC_ADD_HI)
                 || (proc == PROC_CNT_HI) || (proc == PROC_LVL_HI);
  assign ref_rise = (proc == PROC_CYC_R) || (proc == PROC_FREQ_R) || (proc == PROC_ANG_R)
                 || (proc == PROC_DUTY_LH_R) || (proc == PROC_DUTY_HL_R) || (proc == PROC_DUTY_HT_R);
  assign act_now  = act_hi ? meas_in : !meas_in;
  assign act_prev = act_hi ? st_q.in_q : !st_q.in_q;

  // Edge detection is off for a disabled channel
  assign rise    = !is_off && meas_in && !st_q.in_q;
  assign fall    = !is_off && !meas_in && st_q.in_q;
  assign open_e  = !is_off && act_now && !act_prev;
  assign close_e = !is_off && !act_now && act_prev;
  assign ref_e   = ref_rise ? rise : fall;

  // Window only restricts in synchronous mode
  assign in_win    = (cfg_sync_mode == MODE_ASYNC)
                  || ((crank_angle >= cfg_win_lower) && (crank_angle <= cfg_win_upper));
  assign win_end   = (cfg_sync_mode == MODE_SYNC) && ($signed(st_q.ang_q) < cfg_win_upper)
                  && (crank_angle >= cfg_win_upper);
  assign chk_cross = ($signed(st_q.ang_q) < cfg_check_angle) && (crank_angle >= cfg_check_angle);

  assign ang_diff = {crank_angle[ANG_W-1], crank_angle} - {cfg_angle_ref[ANG_W-1], cfg_angle_ref};
  assign ang_rel  = {{(RES_W-ANG_W-1){ang_diff[ANG_W]}}, ang_diff};

  // Duty halves including an update on this very edge
  assign hi_n = fall ? st_q.seg_t : st_q.hi_t;
  assign lo_n = rise ? st_q.seg_t : st_q.lo_t;

  always_comb begin
    case (proc)
      PROC_DUTY_LH_R, PROC_DUTY_LH_F: begin
        num_d = lo_n;
        den_d = hi_n;
      end
      PROC_DUTY_LT_F: begin
        num_d = lo_n;
        den_d = lo_n + hi_n;
      end
      PROC_DUTY_HT_R, PROC_DUTY_HT_F: begin
        num_d = hi_n;
        den_d = lo_n + hi_n;
      end
      default: begin
        num_d = hi_n;
        den_d = lo_n;
      end
    endcase
  end

  // One shared divider: integer Hz for frequency, 16.16 fixed point for duty ratios
  assign num_w = is_frq ? DIV_W'(US_PER_S) : {num_d, {FRAC_W{1'b0}}};
  assign quot  = is_frq ? (num_w / {{FRAC_W{1'b0}}, st_q.per_t})
                        : (num_w / {{FRAC_W{1'b0}}, den_d});

  assign acc_n = st_q.acc + RES_W'(is_add && act_now && in_win && tk.us_tick);
  assign cnt_n = st_q.cnt + RES_W'(is_cnt && close_e && in_win);

  assign int_mode = (cfg_timeout_mode == TO_INT_PRE) || (cfg_timeout_mode == TO_INT_INP)
                 || (cfg_timeout_mode == TO_DUAL_PRE) || (cfg_timeout_mode == TO_DUAL_INP);
  assign ang_mode = (cfg_timeout_mode == TO_ANG_PRE) || (cfg_timeout_mode == TO_ANG_INP)
                 || (cfg_timeout_mode == TO_DUAL_PRE) || (cfg_timeout_mode == TO_DUAL_INP);
  assign mon      = !is_off && (int_mode || ang_mode);
  assign ivl_eff  = (cfg_interval_ms < MS_W'(TO_INTERVAL_MIN_MS)) ? MS_W'(TO_INTERVAL_MIN_MS)
                                                                 : cfg_interval_ms;
  assign chk_int  = int_mode && tk.ms_tick && ((st_q.ms_cnt + MS_W'(1)) >= ivl_eff);
  assign check    = mon && (chk_int || (ang_mode && chk_cross));
  assign fire     = check && !st_q.new_val;

  always_comb begin
    st_d      = st_q;
    st_d.wr   = 1'b0;
    meas_wr   = 1'b0;
    meas_val  = RESULT_RST;
    st_d.in_q  = meas_in;
    st_d.ang_q = crank_angle;

    // Pulse timer: also supplies elapsed active time for input-dependent timeouts
    case (st_q.phase)
      CPM_PH_IDLE: begin
        if (open_e) begin
          st_d.phase   = CPM_PH_OPEN;
          st_d.pulse_t = '0;
          st_d.open_ok = in_win;
          st_d.win_cut = 1'b0;
        end
      end
      CPM_PH_OPEN: begin
        st_d.pulse_t = st_q.pulse_t + RES_W'(tk.us_tick);
        if (win_end) begin
          st_d.win_cut = 1'b1;
        end
        if (close_e || is_off) begin
          st_d.phase = CPM_PH_IDLE;
        end
        if (close_e && is_wid && ((cfg_sync_mode == MODE_ASYNC)
            || (is_eq ? (st_q.open_ok || in_win) : (st_q.open_ok && in_win && !st_q.win_cut)))) begin
          meas_wr  = 1'b1;
          meas_val = st_q.pulse_t;
        end
      end
      default: st_d.phase = CPM_PH_IDLE;
    endcase

    // Edge-to-edge timers
    st_d.seg_t = (rise || fall) ? '0 : st_q.seg_t + RES_W'(tk.us_tick);
    st_d.hi_t  = hi_n;
    st_d.lo_t  = lo_n;
    st_d.per_t = st_q.per_t + RES_W'(tk.us_tick);
    if (ref_e) begin
      st_d.per_t     = '0;
      st_d.have_edge = 1'b1;
      if (st_q.have_edge && in_win) begin
        if (is_cyc) begin
          meas_wr  = 1'b1;
          meas_val = st_q.per_t;
        end
        if ((is_frq && (st_q.per_t != '0)) || (is_duty && (den_d != '0))) begin
          meas_wr  = 1'b1;
          meas_val = quot[RES_W-1:0];
        end
      end
      if (is_ang && in_win) begin
        meas_wr  = 1'b1;
        meas_val = ang_rel;
      end
    end

    // A disabled channel disarms, so a new procedure starts with an arming edge
    if (is_off) begin
      st_d.have_edge = 1'b0;
    end

    // Additive active time and pulse count
    st_d.acc = acc_n;
    st_d.cnt = cnt_n;
    if (cfg_sync_mode == MODE_SYNC) begin
      if (win_end && (is_add || is_cnt)) begin
        meas_wr  = 1'b1;
        meas_val = is_add ? acc_n : cnt_n;
        st_d.acc = '0;
        st_d.cnt = '0;
      end
    end else if (close_e && (is_add || is_cnt)) begin
      meas_wr  = 1'b1;
      meas_val = is_add ? acc_n : cnt_n;
    end

    if (is_lvl && (rise || fall)) begin
      meas_wr  = 1'b1;
      meas_val = {{(RES_W-1){1'b0}}, act_now};
    end

    // Interval counter runs only in interval modes
    if (!int_mode) begin
      st_d.ms_cnt = '0;
    end else if (tk.ms_tick) begin
      st_d.ms_cnt = chk_int ? '0 : st_q.ms_cnt + MS_W'(1);
    end

    // A value arriving in the check cycle wins over the check
    st_d.new_val = meas_wr ? 1'b1 : (check ? 1'b0 : st_q.new_val);
    st_d.mon_off = !mon;
    if (meas_wr) begin
      st_d.result = meas_val;
      st_d.wr     = 1'b1;
      st_d.tout   = 1'b0;
    end else if (fire) begin
      st_d.wr   = 1'b1;
      st_d.tout = 1'b1;
      if (cfg_timeout_mode[0]) begin
        st_d.result = cfg_default_value;
      end else begin
        st_d.result = act_now ? st_q.pulse_t : RESULT_RST;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign result_q      = st_q.result;
  assign result_wr_q   = st_q.wr;
  assign timeout_q     = st_q.tout;
  assign monitor_off_q = st_q.mon_off;

  AST_DISABLED_SILENT: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($past(cfg_procedure) == PROC_OFF) |-> !result_wr_q) else $error("disabled channel wrote a result");
  AST_NO_MONITOR: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($past(cfg_timeout_mode) == TO_OFF) |-> !(result_wr_q && timeout_q)) else $error("timeout while off");
  AST_PRESET_VALUE: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && timeout_q && $past(cfg_timeout_mode[0])) |-> (result_q == $past(cfg_default_value)))
    else $error("preset timeout value wrong");
  AST_INPUT_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && timeout_q && !$past(cfg_timeout_mode[0]) && !$past(act_now)) |-> (result_q == RESULT_RST))
    else $error("inactive input timeout not zero");
  AST_SILENCE_BEFORE_TIMEOUT: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && timeout_q) |-> (!$past(st_q.new_val) && !$past(meas_wr))) else $error("timeout despite new value");
  AST_ANGLE_CHECK_POINT: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && timeout_q && (($past(cfg_timeout_mode) == TO_ANG_PRE) || ($past(cfg_timeout_mode) == TO_ANG_INP)))
    |-> $past(chk_cross)) else $error("angle timeout away from check point");
  AST_SUM_AT_UPPER: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && !timeout_q && $past(is_add || is_cnt) && $past(cfg_sync_mode)) |-> $past(win_end))
    else $error("sum written away from upper limit");
  AST_ANGLE_RELATIVE: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && !timeout_q && $past(is_ang)) |-> (result_q == $past(ang_rel))) else $error("angle not relative");
  AST_LEVEL_VALUE: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && !timeout_q && $past(is_lvl)) |-> (result_q[0] == $past(act_now))) else $error("level wrong");
  AST_PULSE_WINDOW: assert property (@(posedge ref_clk) disable iff (!nrst)
    (result_wr_q && !timeout_q && $past(is_wid && !is_eq && cfg_sync_mode)) |-> $past(in_win))
    else $error("pulse-qualified width outside window");
endmodule : crank_pulse_measure_channel
`default_nettype wire

// [cpm_pkg.sv]
/*
  Constants, codes and types shared by the crank pulse measurement channel.
  Assumes a single 20 MHz reference clock; angles are whole degrees crankshaft.
*/
package cpm_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS      = 50;
  localparam int TICK_NS            = 1000;
  localparam int CYC_PER_US         = TICK_NS / CLK_PERIOD_NS;
  localparam int US_PER_MS          = 1000;
  localparam int US_PER_S           = 1000000;
  localparam int TO_INTERVAL_MIN_MS = 1;

  // Widths
  localparam int ANG_W  = 12;
  localparam int RES_W  = 32;
  localparam int FRAC_W = 16;
  localparam int DIV_W  = RES_W + FRAC_W;
  localparam int MS_W   = 16;

  // Measurement mode
  localparam logic MODE_ASYNC = 1'h0;
  localparam logic MODE_SYNC  = 1'h1;

  // Measurement procedure codes, 8-bit two's complement
  localparam logic [7:0] PROC_OFF       = 8'hff;
  localparam logic [7:0] PROC_HI_PQ     = 8'h00;
  localparam logic [7:0] PROC_LO_PQ     = 8'h01;
  localparam logic [7:0] PROC_ADD_HI    = 8'h02;
  localparam logic [7:0] PROC_ADD_LO    = 8'h03;
  localparam logic [7:0] PROC_FREQ_R    = 8'h04;
  localparam logic [7:0] PROC_FREQ_F    = 8'h05;
  localparam logic [7:0] PROC_DUTY_LH_R = 8'h06;
  localparam logic [7:0] PROC_DUTY_LH_F = 8'h07;
  localparam logic [7:0] PROC_DUTY_HL_R = 8'h08;
  localparam logic [7:0] PROC_DUTY_HL_F = 8'h09;
  localparam logic [7:0] PROC_DUTY_HL_G = 8'h0a;
  localparam logic [7:0] PROC_DUTY_LT_F = 8'h0b;
  localparam logic [7:0] PROC_DUTY_HT_R = 8'h0c;
  localparam logic [7:0] PROC_DUTY_HT_F = 8'h0d;
  localparam logic [7:0] PROC_ANG_R     = 8'h0e;
  localparam logic [7:0] PROC_ANG_F     = 8'h0f;
  localparam logic [7:0] PROC_CNT_LO    = 8'h10;
  localparam logic [7:0] PROC_CNT_HI    = 8'h11;
  localparam logic [7:0] PROC_CYC_R     = 8'h12;
  localparam logic [7:0] PROC_CYC_F     = 8'h13;
  localparam logic [7:0] PROC_LVL_HI    = 8'h31;
  localparam logic [7:0] PROC_LVL_LO    = 8'h32;
  localparam logic [7:0] PROC_HI_EQ     = 8'h3b;
  localparam logic [7:0] PROC_LO_EQ     = 8'h3c;

  // Timeout monitoring codes
  localparam logic [2:0] TO_OFF      = 3'h0;
  localparam logic [2:0] TO_INT_PRE  = 3'h1;
  localparam logic [2:0] TO_INT_INP  = 3'h2;
  localparam logic [2:0] TO_ANG_PRE  = 3'h3;
  localparam logic [2:0] TO_ANG_INP  = 3'h4;
  localparam logic [2:0] TO_DUAL_PRE = 3'h5;
  localparam logic [2:0] TO_DUAL_INP = 3'h6;

  localparam logic [RES_W-1:0] RESULT_RST = 32'h0;

  typedef enum logic [1:0] {
    CPM_PH_IDLE = 2'b01,
    CPM_PH_OPEN = 2'b10
  } cpm_phase_t;

endpackage : cpm_pkg

// [cpm_tick_if.sv]
/*
  Microsecond and millisecond tick strobes from the time base to the channel.
  Both strobes are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface cpm_tick_if;
  logic us_tick;
  logic ms_tick;
  modport src (output us_tick, output ms_tick);
  modport snk (input us_tick, input ms_tick);
endinterface : cpm_tick_if
`default_nettype wire

// [cpm_timebase.sv]
/*
  Time base: divides ref_clk down to microsecond and millisecond strobes.
  Assumes ref_clk at the rate given in cpm_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module cpm_timebase
  import cpm_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  nrst,
  cpm_tick_if.src    tk
);
  localparam int CYC_W = $clog2(CYC_PER_US);
  localparam int USC_W = $clog2(US_PER_MS);

  typedef struct packed {
    logic [CYC_W-1:0] cyc;
    logic [USC_W-1:0] us;
    logic             us_tick;
    logic             ms_tick;
  } cpm_tb_t;

  cpm_tb_t st_q;
  cpm_tb_t st_d;

  always_comb begin
    st_d         = st_q;
    st_d.us_tick = 1'b0;
    st_d.ms_tick = 1'b0;
    if (st_q.cyc == CYC_W'(CYC_PER_US - 1)) begin
      st_d.cyc     = '0;
      st_d.us_tick = 1'b1;
      if (st_q.us == USC_W'(US_PER_MS - 1)) begin
        st_d.us      = '0;
        st_d.ms_tick = 1'b1;
      end else begin
        st_d.us = st_q.us + USC_W'(1);
      end
    end else begin
      st_d.cyc = st_q.cyc + CYC_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tk.us_tick = st_q.us_tick;
  assign tk.ms_tick = st_q.ms_tick;
endmodule : cpm_timebase
`default_nettype wire

// [cpm_signal_model.sv]
/*
  Far-side model: drives the measured input line and the crank angle.
  Assumes its tasks are called from a process that follows ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cpm_signal_model
  import cpm_pkg::*;
(
  input  wire logic                    ref_clk,
  output var  logic                    meas_in,
  output var  logic signed [ANG_W-1:0] crank_angle
);
  initial begin
    meas_in     = 1'h0;
    crank_angle = 12'hf9c;
  end

  // Active for n cycles, then inactive for n cycles
  task automatic pulse(input logic act, input int n);
    @(posedge ref_clk);
    meas_in <= act;
    repeat (n) @(posedge ref_clk);
    meas_in <= ~act;
    repeat (n) @(posedge ref_clk);
  endtask : pulse

  task automatic set_line(input logic lvl, input logic [ANG_W-1:0] ang);
    @(posedge ref_clk);
    meas_in     <= lvl;
    crank_angle <= ang;
    repeat (3) @(posedge ref_clk);
  endtask : set_line
endmodule : cpm_signal_model
`default_nettype wire

// [crank_pulse_measure_channel_bench.sv]
/*
  Self-checking bench for one measurement channel.
  Assumes cpm_signal_model drives the input line and crank angle.
*/
`timescale 1ns/1ps
`default_nettype none
module crank_pulse_measure_channel_bench;
  import cpm_pkg::*;
  logic                    ref_clk;
  logic                    nrst;
  wire logic               meas_in;
  wire logic [ANG_W-1:0]   crank_angle;
  logic                    cfg_sync_mode;
  logic        [7:0]       cfg_procedure;
  logic        [2:0]       cfg_timeout_mode;
  logic        [RES_W-1:0] cfg_default_value;
  logic        [MS_W-1:0]  cfg_interval_ms;
  logic        [ANG_W-1:0] cfg_check_angle;
  logic        [ANG_W-1:0] cfg_win_lower;
  logic        [ANG_W-1:0] cfg_win_upper;
  logic        [ANG_W-1:0] cfg_angle_ref;
  logic        [RES_W-1:0] result_q;
  logic                    result_wr_q;
  logic                    timeout_q;
  logic                    monitor_off_q;
  logic        [RES_W-1:0] last_res;
  logic                    last_to;
  int                      num_errors;
  int                      comparisons;
  int                      wr_cnt;
  int                      base;
  int                      cyc;
  logic        [7:0]       wcode [4] = '{PROC_HI_PQ, PROC_LO_PQ, PROC_HI_EQ, PROC_LO_EQ};

  cpm_signal_model i_src (.ref_clk(ref_clk), .meas_in(meas_in), .crank_angle(crank_angle));
  crank_pulse_measure_channel i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .meas_in(meas_in), .crank_angle(crank_angle),
    .cfg_sync_mode(cfg_sync_mode), .cfg_procedure(cfg_procedure), .cfg_timeout_mode(cfg_timeout_mode),
    .cfg_default_value(cfg_default_value), .cfg_interval_ms(cfg_interval_ms),
    .cfg_check_angle(cfg_check_angle), .cfg_win_lower(cfg_win_lower), .cfg_win_upper(cfg_win_upper),
    .cfg_angle_ref(cfg_angle_ref), .result_q(result_q), .result_wr_q(result_wr_q),
    .timeout_q(timeout_q), .monitor_off_q(monitor_off_q)
  );

  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (result_wr_q === 1'h1) begin
      wr_cnt   <= wr_cnt + 1;
      last_res <= result_q;
      last_to  <= timeout_q;
    end
    if (cyc == 90000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Width results carry up to one microsecond of tick granularity
  task automatic near(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    chk((got + 32'h1 >= exp && got <= exp + 32'h1) ? exp : got, exp);
  endtask : near

  task automatic span(input logic [RES_W-1:0] got, input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi);
    chk((got >= lo && got <= hi) ? lo : got, lo);
  endtask : span

  // Channel off while the line settles, so the code switch makes no edge
  task automatic cfg(input logic [7:0] p, input logic idle, input logic [ANG_W-1:0] ang);
    @(posedge ref_clk);
    cfg_procedure <= PROC_OFF;
    i_src.set_line(idle, ang);
    cfg_procedure <= p;
    repeat (3) @(posedge ref_clk);
    #1 base = wr_cnt;
  endtask : cfg

  task automatic expect_wr(input int n, input int bound);
    for (int i = 0; i < bound && wr_cnt < base + n; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    #1 chk(wr_cnt - base, n);
  endtask : expect_wr

  initial begin
    {nrst, cfg_sync_mode, cfg_procedure, cfg_timeout_mode} = {2'h0, PROC_OFF, TO_OFF};
    {cfg_default_value, cfg_interval_ms, cfg_check_angle} = {32'h1234abcd, 16'h1, 12'h000};
    {cfg_win_lower, cfg_win_upper, cfg_angle_ref} = {12'h00a, 12'h032, 12'h00a};
    {num_errors, comparisons, wr_cnt, base, cyc} = '0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'h1;
    cfg(PROC_OFF, 1'h0, 12'hf9c);
    i_src.pulse(1'h1, 100);
    expect_wr(0, 10);
    chk(monitor_off_q, 32'h1);
    $display("test channel off done");
    for (int i = 0; i < 4; i++) begin
      cfg(wcode[i], i[0], 12'hf9c);
      i_src.pulse(~i[0], 100);
      expect_wr(1, 10);
      near(last_res, 32'h5);
      chk(last_to, 32'h0);
    end
    $display("test pulse widths done");
    cfg(PROC_CNT_HI, 1'h0, 12'hf9c);
    repeat (3) i_src.pulse(1'h1, 40);
    expect_wr(3, 10);
    chk(last_res, 32'h3);
    $display("test pulse count done");
    cfg(PROC_LVL_HI, 1'h0, 12'hf9c);
    i_src.pulse(1'h1, 40);
    expect_wr(2, 10);
    chk(last_res, 32'h0);
    cfg(PROC_CYC_R, 1'h0, 12'hf9c);
    repeat (3) i_src.pulse(1'h1, 100);
    expect_wr(2, 10);
    near(last_res, 32'ha);
    cfg(PROC_FREQ_R, 1'h0, 12'hf9c);
    repeat (3) i_src.pulse(1'h1, 100);
    expect_wr(2, 10);
    span(last_res, 32'h1631d, 32'h1b207);
    cfg(PROC_DUTY_HT_R, 1'h0, 12'hf9c);
    repeat (3) i_src.pulse(1'h1, 100);
    expect_wr(2, 10);
    span(last_res, 32'h71c7, 32'h8e39);
    $display("test level, cycle, frequency and duty done");
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      cfg_angle_ref <= i[0] ? 12'h032 : 12'h00a;
      cfg(PROC_ANG_R, 1'h0, 12'h01e);
      i_src.pulse(1'h1, 40);
      expect_wr(1, 10);
      chk(last_res, i[0] ? 32'hffffffec : 32'h14);
    end
    $display("test edge angle done");
    @(posedge ref_clk);
    cfg_sync_mode <= MODE_SYNC;
    cfg(PROC_HI_PQ, 1'h0, 12'h064);
    i_src.pulse(1'h1, 100);
    expect_wr(0, 10);
    cfg(PROC_HI_EQ, 1'h0, 12'h064);
    i_src.pulse(1'h1, 100);
    expect_wr(0, 10);
    cfg(PROC_HI_PQ, 1'h0, 12'h014);
    i_src.pulse(1'h1, 100);
    expect_wr(1, 10);
    near(last_res, 32'h5);
    $display("test angle window done");
    cfg(PROC_ADD_HI, 1'h0, 12'h014);
    i_src.pulse(1'h1, 100);
    i_src.set_line(1'h0, 12'h064);
    expect_wr(1, 10);
    near(last_res, 32'h5);
    $display("test additive window done");
    @(posedge ref_clk);
    cfg_sync_mode    <= MODE_ASYNC;
    cfg_timeout_mode <= TO_INT_PRE;
    cfg(PROC_HI_PQ, 1'h0, 12'hf9c);
    expect_wr(1, 41000);
    chk(last_res, cfg_default_value);
    chk(last_to, 32'h1);
    chk(monitor_off_q, 32'h0);
    @(posedge ref_clk);
    cfg_timeout_mode <= TO_INT_INP;
    #1 base = wr_cnt;
    expect_wr(1, 21000);
    chk(last_res, 32'h0);
    @(posedge ref_clk);
    cfg_timeout_mode <= TO_DUAL_PRE;
    #1 base = wr_cnt;
    i_src.set_line(1'h0, 12'h01e);
    expect_wr(1, 10);
    chk(last_res, cfg_default_value);
    @(posedge ref_clk);
    cfg_timeout_mode <= TO_ANG_INP;
    #1 base = wr_cnt;
    i_src.set_line(1'h1, 12'hf9c);
    repeat (100) @(posedge ref_clk);
    i_src.set_line(1'h1, 12'h01e);
    expect_wr(1, 10);
    near(last_res, 32'h5);
    chk(last_to, 32'h1);
    @(posedge ref_clk);
    cfg_timeout_mode <= TO_OFF;
    repeat (3) @(posedge ref_clk);
    #1 chk(monitor_off_q, 32'h1);
    $display("test timeout done");
    conclude();
  end
endmodule : crank_pulse_measure_channel_bench
`default_nettype wire
